// ---- core/uel_regs.svh ----
// register indices, field positions, reset values and timing counts
// assumes a 32-bit bus; byte address is four times the register index
`ifndef UEL_REGS_SVH
`define UEL_REGS_SVH
// register indices
`define UEL_IDX_DATA 3'h0
`define UEL_IDX_IER 3'h1
`define UEL_IDX_IIR 3'h2
`define UEL_IDX_LCR 3'h3
`define UEL_IDX_MCR 3'h4
`define UEL_IDX_LSR 3'h5
`define UEL_IDX_MSR 3'h6
`define UEL_IDX_SCR 3'h7
// field positions
`define UEL_LCR_DIVISOR_ACCESS_BIT 7
`define UEL_MCR_DTR 0
`define UEL_MCR_RTS 1
`define UEL_MCR_OUT1 2
`define UEL_MCR_OUT2 3
`define UEL_MCR_AFE 5
`define UEL_FCR_EN 0
`define UEL_FCR_RXRST 1
`define UEL_FCR_TXRST 2
// interrupt identification codes
`define UEL_IIR_NONE 4'h1
`define UEL_IIR_LSI 4'h6
`define UEL_IIR_RDA 4'h4
`define UEL_IIR_HOLDING_EMPTY_FLAG 4'h2
`define UEL_IIR_MSI 4'h0
// reset values
`define UEL_DIV_RST 16'h0001
`define UEL_PINS_RST 6'h3f
// timing counts in 16x ticks, and the stop bit index
`define UEL_LEAD_LAST 4'h8
`define UEL_MID_TICK 4'h7
`define UEL_BIT_LAST 4'hf
`define UEL_STOP_BIT 4'h9
// bus answers
`define UEL_RESP_OKAY 2'b00
`define UEL_RESP_SLVERR 2'b10
`endif

// ---- core/uel_pkg.sv ----
// types shared by the serial channel files
// assumes nothing beyond a single clock domain
package uel_pkg;
	typedef logic [31:0] uel_word_t;
	typedef logic [1:0] uel_resp_t;
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_LEAD = 2'b01, TX_FRAME = 2'b10} uel_tx_state_t;
	typedef enum logic {RX_IDLE = 1'b0, RX_FRAME = 1'b1} uel_rx_state_t;
endpackage : uel_pkg

// ---- core/uel_sync.sv ----
// two-flop synchroniser for a group of pin levels
// assumes the pins are quasi-static against aclk
`timescale 1ns/1ps
module uel_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta; // first stage, read only by q
	// two stages, reset to the idle pin level
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta <= RST_VAL;
			q <= RST_VAL;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : uel_sync

// ---- core/uel_baud_div.sv ----
// baud tick divider: one-cycle tick every divisor clocks
// assumes divisor comes from registers on the same clock
`timescale 1ns/1ps
module uel_baud_div (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] divisor,
	output logic tick
);
	logic [15:0] cnt; // cycles since last tick
	logic [15:0] last; // terminal count, zero acts as one
	assign last = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
	// count up, fire and wrap at the terminal count
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt <= 16'h0000;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (cnt >= last);
			cnt <= (cnt >= last) ? 16'h0000 : cnt + 16'h0001;
		end
	end
	// helper: cycles between ticks while the divisor holds
	logic [15:0] gap;
	logic steady;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || tick)
		begin
			gap <= 16'h0001;
			steady <= aresetn;
		end
		else
		begin
			gap <= gap + 16'h0001;
			steady <= steady && ($past(divisor) == divisor);
		end
	end
	a_tick_period: assert property (@(posedge aclk) disable iff (!aresetn)
		(tick && steady && $past(tick, 1) == 1'b0 && divisor > 16'h0001) |-> gap == divisor)
		else $error("baud tick spacing differs from divisor");
endmodule : uel_baud_div

// ---- core/uel_top.sv ----
// serial channel with event timing, auto flow control, register slave
// assumes AXI4-Lite master on aclk; serial and modem pins are asynchronous
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "uel_regs.svh"
module uel_top #(
	parameter int RX_DEPTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire uel_pkg::uel_word_t s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire uel_pkg::uel_word_t s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output uel_pkg::uel_resp_t s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire uel_pkg::uel_word_t s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output uel_pkg::uel_word_t s_axi_rdata,
	output uel_pkg::uel_resp_t s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_pin,
	input wire logic rclk_pin,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic dcd_n,
	output logic tx_pin,
	output logic rts_n,
	output logic dtr_n,
	output logic out1_n,
	output logic out2_n,
	output logic irq,
	output logic rx_ready_n,
	output logic tx_ready_n
);
	import uel_pkg::*;
	if (RX_DEPTH != 16)
		$error("receive fifo must hold 16 characters");
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [5:0] pins_s; // rclk, rx, dcd, ri, dsr, cts
	uel_sync #(.W(6), .RST_VAL(`UEL_PINS_RST)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({rclk_pin, rx_pin, dcd_n, ri_n, dsr_n, cts_n}),
		.q(pins_s)
	);
	wire rx_s = pins_s[4];
	wire [3:0] modem_s = pins_s[3:0]; // active low levels
	logic rclk_d; // previous receiver clock level
	wire rx_tick = pins_s[5] && !rclk_d;
	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [3:0] ier; // irq enables
	logic [7:0] lcr; // line control
	logic [5:0] modem_control_reg; // modem control
	logic [7:0] scr; // scratch
	logic [7:0] dll; // divisor low byte
	logic [7:0] divisor_high_byte;
	logic fcr_en; // fifo mode
	logic rd_lsr; // line status read taken
	logic rd_msr; // modem status read taken
	logic iir_clr; // ident read of empty irq ends
	logic [1:0] trig; // threshold select
	wire divisor_access_bit = lcr[`UEL_LCR_DIVISOR_ACCESS_BIT];
	wire afe = modem_control_reg[`UEL_MCR_AFE];
	logic tick; // 16x baud tick
	uel_baud_div u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.divisor({divisor_high_byte, dll}),
		.tick(tick)
	);
	// ----------------------------------------
	// bus write channel
	// ----------------------------------------
	logic [31:0] aw_addr_q;
	logic [7:0] wbyte;
	logic lane0; // low byte strobe held
	wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire wr_ok = (aw_addr_q[31:5] == 27'h0);
	wire wr_en = wr_fire && wr_ok && lane0;
	wire [2:0] wr_idx = aw_addr_q[4:2];
	wire wr_data = wr_en && wr_idx == `UEL_IDX_DATA;
	wire wr_thr = wr_data && !divisor_access_bit;
	wire wr_dll = wr_data && divisor_access_bit;
	wire wr_ier = wr_en && wr_idx == `UEL_IDX_IER && !divisor_access_bit;
	wire wr_dlm = wr_en && wr_idx == `UEL_IDX_IER && divisor_access_bit;
	wire wr_fcr = wr_en && wr_idx == `UEL_IDX_IIR;
	wire wr_lcr = wr_en && wr_idx == `UEL_IDX_LCR;
	wire wr_mcr = wr_en && wr_idx == `UEL_IDX_MCR;
	wire wr_scr = wr_en && wr_idx == `UEL_IDX_SCR;
	// address and data taken in either order, answer after both
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `UEL_RESP_OKAY;
			aw_addr_q <= 32'h0;
			wbyte <= 8'h00;
			lane0 <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				wbyte <= s_axi_wdata[7:0];
				lane0 <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `UEL_RESP_OKAY : `UEL_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	// control registers; divisor_access_bit steers the two low indices
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ier <= 4'h0;
			lcr <= 8'h00;
			modem_control_reg <= 6'h00;
			scr <= 8'h00;
			dll <= 8'(`UEL_DIV_RST);
			divisor_high_byte <= 8'h00;
			fcr_en <= 1'b0;
			trig <= 2'b00;
		end
		else
		begin
			if (wr_ier) ier <= wbyte[3:0];
			if (wr_lcr) lcr <= wbyte;
			if (wr_mcr) modem_control_reg <= wbyte[5:0];
			if (wr_scr) scr <= wbyte;
			if (wr_dll) dll <= wbyte;
			if (wr_dlm) divisor_high_byte <= wbyte;
			if (wr_fcr)
			begin
				fcr_en <= wbyte[`UEL_FCR_EN];
				trig <= wbyte[7:6];
			end
		end
	end
	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	uel_tx_state_t tx_state;
	logic [3:0] tx_cnt; // ticks within bit or lead
	logic [3:0] tx_bit; // 0 start, 1-8 data, 9 stop
	logic [7:0] tx_sh; // shifter
	logic [7:0] transmit_holding_reg;
	logic thr_full; // holding register loaded
	logic cts_ok; // cts judged at stop midpoint
	logic holding_empty_flag; // status bit 5
	logic holding_empty_flag_pend; // empty irq pending
	wire cts_go = !afe || !modem_s[0];
	wire tx_rst = wr_fcr && wbyte[`UEL_FCR_TXRST];
	wire in_frame = tx_state == TX_FRAME;
	wire bit_end = in_frame && tick && tx_cnt == `UEL_BIT_LAST;
	wire stop_end = bit_end && tx_bit == `UEL_STOP_BIT;
	wire next_go = thr_full && cts_ok;
	wire lead_done = tx_state == TX_LEAD && tick && tx_cnt == `UEL_LEAD_LAST;
	wire tx_load = lead_done || (stop_end && next_go);
	wire holding_empty_flag_set = in_frame && tx_bit == 4'h0 && tick && tx_cnt == `UEL_MID_TICK
		&& !thr_full && !wr_thr;
	wire temt = holding_empty_flag && tx_state == TX_IDLE;
	// frame sequencer: lead delay, start, data lsb first, stop
	always_ff @(posedge aclk)
	begin
		if (!aresetn || tx_rst)
		begin
			tx_state <= TX_IDLE;
			tx_cnt <= 4'h0;
			tx_bit <= 4'h0;
			tx_sh <= 8'hff;
			tx_pin <= 1'b1;
			cts_ok <= 1'b0;
		end
		else
		begin
			unique case (tx_state)
				TX_IDLE:
				begin
					if (thr_full && cts_go)
					begin
						tx_state <= TX_LEAD;
						tx_cnt <= 4'h0;
					end
				end
				TX_LEAD:
				begin
					if (tick) tx_cnt <= tx_cnt + 4'h1;
				end
				TX_FRAME:
				begin
					if (tick) tx_cnt <= tx_cnt + 4'h1;
					if (tick && tx_cnt == `UEL_MID_TICK && tx_bit == `UEL_STOP_BIT)
						cts_ok <= cts_go;
					if (bit_end && tx_bit != `UEL_STOP_BIT)
					begin
						tx_bit <= tx_bit + 4'h1;
						tx_pin <= tx_sh[0];
						tx_sh <= {1'b1, tx_sh[7:1]};
					end
					if (stop_end && !next_go) tx_state <= TX_IDLE;
				end
			endcase
			if (tx_load)
			begin
				tx_state <= TX_FRAME;
				tx_sh <= transmit_holding_reg;
				tx_bit <= 4'h0;
				tx_cnt <= 4'h0;
				tx_pin <= 1'b0;
			end
		end
	end
	// holding register, empty flag, ready pin and empty irq
	always_ff @(posedge aclk)
	begin
		if (!aresetn || tx_rst)
		begin
			thr_full <= 1'b0;
			holding_empty_flag <= 1'b1;
			tx_ready_n <= 1'b0;
			holding_empty_flag_pend <= 1'b0;
			if (!aresetn) transmit_holding_reg <= 8'h00;
		end
		else
		begin
			if (tx_load) thr_full <= 1'b0;
			if (holding_empty_flag_set)
			begin
				holding_empty_flag <= 1'b1;
				tx_ready_n <= 1'b0;
				holding_empty_flag_pend <= 1'b1;
			end
			else if (iir_clr) holding_empty_flag_pend <= 1'b0;
			if (wr_thr)
			begin
				transmit_holding_reg <= wbyte;
				thr_full <= 1'b1;
				holding_empty_flag <= 1'b0;
				tx_ready_n <= 1'b1;
				holding_empty_flag_pend <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// receiver and fifo
	// ----------------------------------------
	uel_rx_state_t rx_state;
	logic [3:0] rx_cnt;
	logic [3:0] rx_bit;
	logic [7:0] rx_sh;
	logic [7:0] rx_mem [RX_DEPTH];
	logic [3:0] wp;
	logic [3:0] rp;
	logic [4:0] rx_count;
	logic oe_flag; // overrun
	logic fe_flag; // framing error
	logic rts_hold; // auto rts holding the peer off
	wire rx_sample = rx_state == RX_FRAME && rx_tick && rx_cnt == `UEL_MID_TICK;
	wire rx_push = rx_sample && rx_bit == `UEL_STOP_BIT;
	wire push_ok = rx_push && rx_count != 5'h10;
	wire rx_rst = wr_fcr && wbyte[`UEL_FCR_RXRST];
	wire [4:0] trig_lvl = !fcr_en ? 5'h01 : trig == 2'b00 ? 5'h01 : trig == 2'b01 ? 5'h04
		: trig == 2'b10 ? 5'h08 : 5'h0e;
	logic rx_pop;
	wire [4:0] next_rx_count = rx_count + {4'h0, push_ok} - {4'h0, rx_pop};
	wire sixteenth = rx_sample && rx_bit == 4'h1 && rx_count == 5'h0f;
	wire rts_set = (push_ok && next_rx_count >= trig_lvl) || sixteenth;
	wire rts_clr = rx_pop && (rx_count == 5'h01 || rx_count == 5'h10);
	wire rda_pend = rx_count >= trig_lvl;
	wire lsi_pend = oe_flag || fe_flag;
	// start detect, mid-bit sampling, false start rejection
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_state <= RX_IDLE;
			rx_cnt <= 4'h0;
			rx_bit <= 4'h0;
			rx_sh <= 8'h00;
			rclk_d <= 1'b1;
		end
		else
		begin
			rclk_d <= pins_s[5];
			if (rx_state == RX_IDLE && rx_tick && !rx_s)
			begin
				rx_state <= RX_FRAME;
				rx_cnt <= 4'h0;
				rx_bit <= 4'h0;
			end
			else if (rx_state == RX_FRAME && rx_tick)
			begin
				rx_cnt <= rx_cnt + 4'h1;
				if (rx_sample)
				begin
					rx_bit <= rx_bit + 4'h1;
					if (rx_bit != 4'h0) rx_sh <= {rx_s, rx_sh[7:1]};
					if ((rx_bit == 4'h0 && rx_s) || rx_push) rx_state <= RX_IDLE;
				end
			end
		end
	end
	// fifo storage
	always_ff @(posedge aclk)
	begin
		if (push_ok) rx_mem[wp] <= rx_sh;
	end
	// fifo pointers, count, flow control, ready pin
	always_ff @(posedge aclk)
	begin
		if (!aresetn || rx_rst)
		begin
			wp <= 4'h0;
			rp <= 4'h0;
			rx_count <= 5'h00;
			rts_hold <= 1'b0;
			rx_ready_n <= 1'b1;
		end
		else
		begin
			if (push_ok) wp <= wp + 4'h1;
			if (rx_pop) rp <= rp + 4'h1;
			rx_count <= next_rx_count;
			rx_ready_n <= next_rx_count == 5'h00;
			if (rts_set) rts_hold <= 1'b1;
			else if (rts_clr) rts_hold <= 1'b0;
		end
	end
	// line status errors: event wins over the clearing read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			oe_flag <= 1'b0;
			fe_flag <= 1'b0;
		end
		else
		begin
			oe_flag <= (oe_flag && !rd_lsr) || (rx_push && !push_ok);
			fe_flag <= (fe_flag && !rd_lsr) || (rx_push && !rx_s);
		end
	end
	// ----------------------------------------
	// modem status and interrupt priority
	// ----------------------------------------
	logic [3:0] modem_q; // previous levels
	logic [3:0] delta; // dcts, ddsr, teri, ddcd
	wire [3:0] chg = {modem_s[3] ^ modem_q[3], modem_s[2] && !modem_q[2],
		modem_s[1] ^ modem_q[1], modem_s[0] ^ modem_q[0]};
	wire [3:0] iir_id = (ier[2] && lsi_pend) ? `UEL_IIR_LSI
		: (ier[0] && rda_pend) ? `UEL_IIR_RDA
		: (ier[1] && holding_empty_flag_pend) ? `UEL_IIR_HOLDING_EMPTY_FLAG
		: (ier[3] && |delta) ? `UEL_IIR_MSI : `UEL_IIR_NONE;
	// change capture, modem outputs and irq pin
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			modem_q <= 4'hf;
			delta <= 4'h0;
			irq <= 1'b0;
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
			out1_n <= 1'b1;
			out2_n <= 1'b1;
		end
		else
		begin
			modem_q <= modem_s;
			delta <= (delta & ~{4{rd_msr}}) | chg;
			irq <= iir_id != `UEL_IIR_NONE;
			rts_n <= !(modem_control_reg[`UEL_MCR_RTS] && !(afe && rts_hold));
			dtr_n <= !modem_control_reg[`UEL_MCR_DTR];
			out1_n <= !modem_control_reg[`UEL_MCR_OUT1];
			out2_n <= !modem_control_reg[`UEL_MCR_OUT2];
		end
	end
	// ----------------------------------------
	// bus read channel
	// ----------------------------------------
	wire ar_fire = s_axi_arvalid && s_axi_arready;
	wire rd_ok = (s_axi_araddr[31:5] == 27'h0);
	wire [2:0] rd_idx = s_axi_araddr[4:2];
	wire rd_hit = ar_fire && rd_ok;
	wire receive_buffer_read = rd_hit && rd_idx == `UEL_IDX_DATA && !divisor_access_bit;
	wire rd_iir = rd_hit && rd_idx == `UEL_IDX_IIR;
	assign rd_lsr = rd_hit && rd_idx == `UEL_IDX_LSR;
	assign rd_msr = rd_hit && rd_idx == `UEL_IDX_MSR;
	assign rx_pop = receive_buffer_read && rx_count != 5'h00;
	wire [7:0] line_status_reg = {1'b0, temt, holding_empty_flag, 2'b00, fe_flag, oe_flag,
		rx_count != 5'h00};
	wire [7:0] modem_status_reg = {~modem_s, delta};
	wire [7:0] rd_val = !rd_ok ? 8'h00
		: rd_idx == `UEL_IDX_DATA ? (divisor_access_bit ? dll : rx_mem[rp])
		: rd_idx == `UEL_IDX_IER ? (divisor_access_bit ? divisor_high_byte : {4'h0, ier})
		: rd_idx == `UEL_IDX_IIR ? {fcr_en, fcr_en, 2'b00, iir_id}
		: rd_idx == `UEL_IDX_LCR ? lcr
		: rd_idx == `UEL_IDX_MCR ? {2'b00, modem_control_reg}
		: rd_idx == `UEL_IDX_LSR ? line_status_reg
		: rd_idx == `UEL_IDX_MSR ? modem_status_reg : scr;
	logic iir_holding_empty_flag_q; // last ident read reported empty irq
	assign iir_clr = s_axi_rvalid && s_axi_rready && iir_holding_empty_flag_q;
	// one read at a time, answered the cycle after address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `UEL_RESP_OKAY;
			iir_holding_empty_flag_q <= 1'b0;
		end
		else if (ar_fire)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h0, rd_val};
			s_axi_rresp <= rd_ok ? `UEL_RESP_OKAY : `UEL_RESP_SLVERR;
			iir_holding_empty_flag_q <= rd_iir && iir_id == `UEL_IIR_HOLDING_EMPTY_FLAG;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
			iir_holding_empty_flag_q <= 1'b0;
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [4:0] since_wr; // ticks since write to idle sender
	logic first_start; // waiting for first start bit
	always_ff @(posedge aclk)
	begin
		if (!aresetn || tx_rst)
		begin
			since_wr <= 5'h00;
			first_start <= 1'b0;
		end
		else if (wr_thr && tx_state == TX_IDLE && !thr_full && cts_go)
		begin
			since_wr <= 5'h00;
			first_start <= 1'b1;
		end
		else
		begin
			if (tick && since_wr != 5'h1f) since_wr <= since_wr + 5'h01;
			// a cts hold-off defers the start; its bound is checked elsewhere
			if (tx_load || !cts_go) first_start <= 1'b0;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_rts_up;
		##[1:2] rts_n;
	endsequence
	sequence s_rts_down;
		##[1:2] !rts_n;
	endsequence
	a_rx_ready_stop: assert property (push_ok |=> !rx_ready_n)
		else $error("rx_ready_n not low after stop sample");
	a_rclk_sample: assert property ((rx_state == RX_FRAME && $changed(rx_bit)) |->
		$past(rx_tick)) else $error("receive bit advanced without receiver clock");
	a_lsr_clear: assert property ((rd_lsr && !rx_push) |=> !lsi_pend)
		else $error("line status read left error pending");
	a_rts_off: assert property ((afe && modem_control_reg[1] && rts_set) |-> s_rts_up)
		else $error("auto rts not raised");
	a_rts_on: assert property ((afe && modem_control_reg[1] && rts_clr && !rts_set) |-> s_rts_down)
		else $error("auto rts not released");
	a_start_window: assert property ((first_start && tx_load) |->
		(since_wr >= 5'h08 && since_wr <= 5'h18)) else $error("start bit outside window");
	a_holding_empty_flag_timing: assert property ($fell(tx_ready_n) |-> (in_frame && tx_bit == 4'h0
		&& tx_cnt == 4'h8 && holding_empty_flag_pend)) else $error("empty irq off start offset");
	a_thr_write: assert property (wr_thr |=> (tx_ready_n && !holding_empty_flag_pend && thr_full))
		else $error("holding write did not clear empty state");
	a_iir_clear: assert property ((iir_clr && !holding_empty_flag_set && !wr_thr) |=> !holding_empty_flag_pend)
		else $error("ident read did not clear empty irq");
	a_cts_stop: assert property ((stop_end && afe && !cts_ok) |=>
		(tx_state == TX_IDLE && tx_pin)) else $error("sender passed cts hold-off");
	a_mcr_out: assert property (wr_mcr |-> ##2 (dtr_n == !$past(wbyte[0], 2)))
		else $error("dtr_n did not follow modem control");
	a_msr_clear: assert property ((rd_msr && chg == 4'h0) |=> delta == 4'h0)
		else $error("modem status read left change pending");
	a_divisor_access_bit_map: assert property ((ar_fire && divisor_access_bit && rd_ok
		&& rd_idx == `UEL_IDX_DATA) |=> s_axi_rdata[7:0] == $past(dll))
		else $error("divisor byte not mapped at index zero");
	a_bit_tick: assert property ((in_frame && $changed(tx_bit) && !$past(tx_load)) |->
		$past(tick)) else $error("transmit bit advanced without tick");
endmodule : uel_top

// ---- tb/uel_peer.sv ----
// remote serial peer: receiver clock, frame sender, frame catcher
// assumes 8n1 frames; the catcher's bit time is given in ns
`timescale 1ns/1ps
module uel_peer #(
	parameter int BIT_NS = 1280
) (
	output logic rclk,
	output logic line_out,
	input wire logic line_in,
	output logic [7:0] got,
	output logic got_stb
);
	initial rclk = 1'b0;
	initial line_out = 1'b1;
	initial got_stb = 1'b0;
	// free 16x receiver clock, well under aclk/4
	always #160 rclk = ~rclk;
	// one frame, each bit held for 16 receiver clocks
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(negedge rclk);
			line_out <= f[i];
			repeat (15) @(negedge rclk);
		end
	endtask : send
	// catch a frame from the device, sampling mid-bit
	always @(negedge line_in)
	begin
		#(BIT_NS / 2);
		for (int i = 0; i < 8; i++)
		begin
			#(BIT_NS);
			got[i] = line_in;
		end
		got_stb = 1'b1;
		#(BIT_NS);
		got_stb = 1'b0;
	end
endmodule : uel_peer

// ---- tb/uel_top_tb.sv ----
// bench: bus tasks, read scoreboard, serial peer
// assumes divisor 2, so one bit is 32 clocks
`timescale 1ns/1ps
module uel_top_tb;
	import uel_pkg::*;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	uel_word_t s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	uel_resp_t s_axi_bresp, s_axi_rresp, hq[$];
	logic rx_pin, rclk_pin, cts_n = 0, dsr_n = 1, ri_n = 1, dcd_n = 1, got_stb;
	logic tx_pin, rts_n, dtr_n, out1_n, out2_n, irq, rx_ready_n, tx_ready_n;
	logic [7:0] got, r = 8'h0b;
	int fails = 0, n_tests = 0, c, k;
	uel_word_t eq[$], mq[$], fq[$];
	always #20 aclk = ~aclk;
	uel_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_pin, .rclk_pin,
		.cts_n, .dsr_n, .ri_n, .dcd_n, .tx_pin, .rts_n, .dtr_n, .out1_n, .out2_n, .irq,
		.rx_ready_n, .tx_ready_n);
	uel_peer i_peer (.rclk(rclk_pin), .line_out(rx_pin), .line_in(tx_pin), .got, .got_stb);
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// write: address and data offered together, each released when taken
	task automatic wr(input uel_word_t a, input logic [7:0] d, input uel_resp_t er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp === er, "write response");
	endtask : wr
	// read: expected word, mask and response noted for the monitor
	task automatic rd(input uel_word_t a, e, m, input uel_resp_t er);
		@(posedge aclk);
		eq.push_back(e);
		mq.push_back(m);
		hq.push_back(er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic tx_wait(output int n);
		n = 0;
		while (tx_pin === 1'b1 && n < 80)
		begin
			@(posedge aclk);
			n++;
		end
	endtask : tx_wait
	// monitor: oldest note against each read answer
	always @(posedge aclk)
		if (s_axi_rvalid && s_axi_rready)
		begin
			n_tests++;
			if ((s_axi_rdata & mq[0]) !== (eq[0] & mq[0]) || s_axi_rresp !== hq[0])
			begin
				fails++;
				$display("wrong value at %0t: read %h", $time, s_axi_rdata);
			end
			void'(eq.pop_front());
			void'(mq.pop_front());
			void'(hq.pop_front());
		end
	initial
	begin
		repeat (80000) @(posedge aclk);
		fails++;
		close_out;
	end
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk(tx_pin === 1'b1 && rts_n === 1'b1 && tx_ready_n === 1'b0 && irq === 1'b0, "reset");
		wr(32'hc, 8'h80, 2'b00);
		wr(32'h0, 8'h02, 2'b00);
		wr(32'h4, 8'h00, 2'b00);
		wr(32'hc, 8'h03, 2'b00);
		wr(32'h100, 8'hff, 2'b10);
		rd(32'h100, 0, 32'hffffffff, 2'b10);
		wr(32'h1c, r, 2'b00);
		rd(32'h1c, {24'h0, r}, 32'hffffffff, 2'b00);
		wr(32'h10, 8'h23, 2'b00);
		repeat (2) @(posedge aclk);
		chk(dtr_n === 1'b0 && rts_n === 1'b0 && out1_n === 1'b1, "modem outputs");
		chk(out2_n === 1'b1, "out2 idle");
		wr(32'h8, 8'h01, 2'b00);
		wr(32'h4, 8'h01, 2'b00);
		r = lfsr(r);
		i_peer.send(r);
		chk(rx_ready_n === 1'b0 && irq === 1'b1, "byte arrival");
		chk(rts_n === 1'b1, "rts at threshold");
		rd(32'h0, {24'h0, r}, 32'hff, 2'b00);
		repeat (4) @(posedge aclk);
		chk(irq === 1'b0 && rts_n === 1'b0 && rx_ready_n === 1'b1, "after read");
		wr(32'h8, 8'hc1, 2'b00);
		for (int i = 0; i < 16; i++)
		begin
			r = lfsr(r);
			fq.push_back({24'h0, r});
			i_peer.send(r);
		end
		chk(rts_n === 1'b1, "full fifo");
		rd(32'h0, fq.pop_front(), 32'hff, 2'b00);
		repeat (4) @(posedge aclk);
		chk(rts_n === 1'b0, "full read");
		while (fq.size() > 0) rd(32'h0, fq.pop_front(), 32'hff, 2'b00);
		wr(32'h4, 8'h02, 2'b00);
		repeat (3) @(posedge aclk);
		chk(irq === 1'b0, "no empty irq before first send");
		r = lfsr(r);
		wr(32'h0, r, 2'b00);
		@(posedge aclk);
		chk(tx_ready_n === 1'b1 && irq === 1'b0, "write taken");
		tx_wait(c);
		chk(c + 2 >= 16 && c + 2 <= 48, "start latency");
		k = 0;
		while (irq !== 1'b1 && k < 30)
		begin
			@(posedge aclk);
			k++;
		end
		chk(k >= 16 && k <= 20, "irq after start");
		chk(c + k + 2 >= 32 && c + k + 2 <= 68, "irq after write");
		chk(tx_ready_n === 1'b0 && k <= 18, "ready after start");
		@(posedge got_stb);
		chk(got === r, "serial byte");
		repeat (2) @(posedge aclk);
		rd(32'h8, 32'h2, 32'hf, 2'b00);
		repeat (2) @(posedge aclk);
		chk(irq === 1'b0, "ident clears");
		cts_n <= 1'b1;
		r = lfsr(r);
		wr(32'h0, r, 2'b00);
		repeat (60) @(posedge aclk);
		chk(tx_pin === 1'b1, "cts hold");
		cts_n <= 1'b0;
		tx_wait(c);
		chk(c <= 48, "cts start");
		@(posedge got_stb);
		chk(got === r, "second byte");
		wr(32'h4, 8'h08, 2'b00);
		dsr_n <= 1'b0;
		repeat (5) @(posedge aclk);
		chk(irq === 1'b1, "modem change");
		rd(32'h18, 32'h22, 32'h22, 2'b00);
		repeat (2) @(posedge aclk);
		chk(irq === 1'b0, "status read clears");
		close_out;
	end
endmodule : uel_top_tb
